// ### wcrc_pkg.sv
package wcrc_pkg;

    // timebase
    localparam longint WCRC_CLK_HZ = 25_000_000;
    localparam longint WCRC_T_WAKE_A_MS = 1000;
    localparam longint WCRC_T_WAKE_B_MS = 10000;
    localparam longint WCRC_T_WAKE_C_MS = 100000;
    localparam longint WCRC_CYC_WAKE_A = WCRC_CLK_HZ * WCRC_T_WAKE_A_MS / 1000;
    localparam longint WCRC_CYC_WAKE_B = WCRC_CLK_HZ * WCRC_T_WAKE_B_MS / 1000;
    localparam longint WCRC_CYC_WAKE_C = WCRC_CLK_HZ * WCRC_T_WAKE_C_MS / 1000;

    // retransmission intervals, counted in timer wake-ups
    localparam logic [7:0] WCRC_RETX_EVERY = 8'h01;
    localparam logic [7:0] WCRC_RETX_A_LO = 8'h07;
    localparam logic [7:0] WCRC_RETX_A_HI = 8'h0e;
    localparam logic [7:0] WCRC_RETX_B_LO = 8'h46;
    localparam logic [7:0] WCRC_RETX_B_HI = 8'h8c;
    localparam logic [7:0] WCRC_RETX_CNT_RST = 8'h01;

    // random source
    localparam logic [15:0] WCRC_LFSR_SEED = 16'hace1;
    localparam logic [15:0] WCRC_LFSR_TAPS = 16'hb400;

    // register indices
    localparam logic [3:0] WCRC_REG_CTRL = 4'h0;
    localparam logic [3:0] WCRC_REG_STATUS = 4'h1;
    localparam logic [3:0] WCRC_REG_MASK = 4'h2;
    localparam logic [3:0] WCRC_REG_STATE = 4'h3;

    // ctrl fields
    localparam int WCRC_CTRL_OCC_PROFILE = 0;
    localparam logic [31:0] WCRC_CTRL_RST = 32'h0000_0001;

    // status / mask fields
    localparam int WCRC_EV_W = 4;
    localparam int WCRC_EV_TIMER = 0;
    localparam int WCRC_EV_PIN = 1;
    localparam int WCRC_EV_RETX = 2;
    localparam int WCRC_EV_SHDN = 3;
    localparam logic [3:0] WCRC_MASK_RST = 4'h0;

    // state readout fields
    localparam int WCRC_ST_CNT = 0;
    localparam int WCRC_ST_WP = 8;
    localparam int WCRC_ST_RM = 10;
    localparam int WCRC_ST_PWR = 12;

    // strap codes {sel1, sel0}; open reads 1
    typedef enum logic [1:0] {
        WCRC_WP_NONE = 2'b00,
        WCRC_WP_1S = 2'b01,
        WCRC_WP_10S = 2'b10,
        WCRC_WP_100S = 2'b11
    } wcrc_wp_t;

    typedef enum logic [1:0] {
        WCRC_RM_NONE = 2'b00,
        WCRC_RM_EVERY = 2'b10,
        WCRC_RM_RAND_A = 2'b11,
        WCRC_RM_RAND_B = 2'b01
    } wcrc_rm_t;

    typedef enum logic [1:0] {
        WCRC_PWR_OFF = 2'b01,
        WCRC_PWR_ON = 2'b10
    } wcrc_pwr_t;

endpackage

// ### wcrc_rand.sv
`timescale 1ns/10ps
`default_nettype none

module wcrc_rand
    import wcrc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] lo,
    input wire logic [7:0] hi,
    output logic [7:0] value
);

    logic [15:0] lfsr;
    logic [8:0] span;
    logic [24:0] scaled;

    // free-running, so the draw depends on when the reload happens
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            lfsr <= WCRC_LFSR_SEED;
        else
            lfsr <= lfsr[0] ? ((lfsr >> 1) ^ WCRC_LFSR_TAPS) : (lfsr >> 1);
    end

    // scale onto [lo, hi] inclusive; lfsr stays below 0x10000, so the floor reaches hi but never passes it
    assign span = {1'b0, hi} - {1'b0, lo} + 9'd1;
    assign scaled = {9'h000, lfsr} * {16'h0000, span};
    assign value = lo + scaled[23:16];

endmodule // wcrc_rand

`default_nettype wire

// ### wcrc_top.sv
// Summary of operation
// - supply above turn-on enables always-on domain
// - supply at/below turn-off starts shutdown
// - straps resampled at every wake-up
// - wake straps pick 1, 10, 100 s
// - both wake straps grounded: no cyclic wake
// - retransmit counter decrements per timer wake
// - counter at zero sends retransmission
// - rate code every: retransmit each timer wake
// - both open: random 7 to 14 wakes
// - rate code B: random 70 to 140
// - both rate straps grounded: never retransmit
// - teach-in pin wake-up always sends telegram
// - reload counter randomly after each transmission
// - teach-in pin falling edge sends teach-in
// - occupancy pin change wakes, sends if profiled
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module wcrc_top
    import wcrc_pkg::*;
#(
    parameter logic [31:0] CYC_WAKE_A = WCRC_CYC_WAKE_A[31:0],
    parameter logic [31:0] CYC_WAKE_B = WCRC_CYC_WAKE_B[31:0],
    parameter logic [31:0] CYC_WAKE_C = WCRC_CYC_WAKE_C[31:0]
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic supply_above_on,
    input wire logic supply_at_or_below_off,
    input wire logic wake_period_sel0,
    input wire logic wake_period_sel1,
    input wire logic retx_rate_sel0,
    input wire logic retx_rate_sel1,
    input wire logic teach_in_wake_pin,
    input wire logic occupancy_wake_pin,
    input wire logic [3:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    output logic always_on_supply_en,
    output logic watchdog_en,
    output logic wake_pin_en,
    output logic shutdown_start,
    output logic telegram_tx,
    output logic retx_tx,
    output logic teach_in_tx,
    output logic occupancy_tx,
    output logic irq
);

    function automatic logic [31:0] period_of(input wcrc_wp_t m);
        unique case (m)
            WCRC_WP_1S: period_of = CYC_WAKE_A;
            WCRC_WP_10S: period_of = CYC_WAKE_B;
            WCRC_WP_100S: period_of = CYC_WAKE_C;
            WCRC_WP_NONE: period_of = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // power state

    wcrc_pwr_t pwr;
    wcrc_pwr_t next_pwr;
    logic powered;
    logic shdn_ev;

    assign powered = (pwr == WCRC_PWR_ON);
    assign shdn_ev = powered && supply_at_or_below_off;

    always_comb
    begin
        next_pwr = pwr;
        unique case (pwr)
            WCRC_PWR_OFF: if (supply_above_on && !supply_at_or_below_off) next_pwr = WCRC_PWR_ON;
            WCRC_PWR_ON: if (supply_at_or_below_off) next_pwr = WCRC_PWR_OFF;
            default: next_pwr = WCRC_PWR_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwr <= WCRC_PWR_OFF;
        else
            pwr <= next_pwr;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wake sources

    logic teach_q;
    logic occ_q;
    logic straps_ok;
    logic primed;
    wcrc_wp_t wp_mode;
    wcrc_rm_t rm_mode;
    logic [31:0] tcnt;
    logic [31:0] period;
    logic timer_wake;
    logic teach_wake;
    logic occ_wake;
    logic pin_wake;
    logic wake_any;

    assign period = period_of(wp_mode);
    // no edge counts while the pin circuitry is unpowered
    assign teach_wake = powered && teach_q && !teach_in_wake_pin;
    assign occ_wake = powered && (occ_q != occupancy_wake_pin);
    assign pin_wake = teach_wake || occ_wake;
    assign timer_wake = powered && (wp_mode != WCRC_WP_NONE) && (tcnt >= period - 32'd1);
    assign wake_any = timer_wake || pin_wake;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            teach_q <= 1'b1;
            occ_q <= 1'b1;
            tcnt <= 32'h0000_0000;
        end
        else
        begin
            teach_q <= teach_in_wake_pin;
            occ_q <= occupancy_wake_pin;
            if (!powered || wp_mode == WCRC_WP_NONE || timer_wake)
                tcnt <= 32'h0000_0000;
            else
                tcnt <= tcnt + 32'd1;
        end
    end

    // open straps pull up to 1; first capture lands one cycle after reset release
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            straps_ok <= 1'b0;
            wp_mode <= WCRC_WP_NONE;
            rm_mode <= WCRC_RM_NONE;
        end
        else if (!straps_ok || wake_any)
        begin
            straps_ok <= 1'b1;
            wp_mode <= wcrc_wp_t'({wake_period_sel1, wake_period_sel0});
            rm_mode <= wcrc_rm_t'({retx_rate_sel1, retx_rate_sel0});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // retransmission counter

    logic [7:0] cnt;
    logic [7:0] cnt_dec;
    logic [7:0] rnd_lo;
    logic [7:0] rnd_hi;
    logic [7:0] reload;
    logic retx_fire;
    logic occ_send;
    logic tx_any;
    logic [31:0] ctrl;

    assign rnd_lo = (rm_mode == WCRC_RM_RAND_B) ? WCRC_RETX_B_LO :
                    (rm_mode == WCRC_RM_RAND_A) ? WCRC_RETX_A_LO : WCRC_RETX_EVERY;
    assign rnd_hi = (rm_mode == WCRC_RM_RAND_B) ? WCRC_RETX_B_HI :
                    (rm_mode == WCRC_RM_RAND_A) ? WCRC_RETX_A_HI : WCRC_RETX_EVERY;

    wcrc_rand u_rand
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lo(rnd_lo),
        .hi(rnd_hi),
        .value(reload)
    );

    // a zero count is treated as one so a stale value never wraps
    assign cnt_dec = (cnt <= 8'd1) ? 8'h00 : cnt - 8'd1;
    // every-wake mode fires regardless of a count left over from a random mode
    assign retx_fire = timer_wake && (rm_mode != WCRC_RM_NONE)
                       && (cnt_dec == 8'h00 || rm_mode == WCRC_RM_EVERY);
    assign occ_send = occ_wake && ctrl[WCRC_CTRL_OCC_PROFILE];
    assign tx_any = retx_fire || teach_wake || occ_send;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= WCRC_RETX_CNT_RST;
            primed <= 1'b0;
        end
        else if (straps_ok && (!primed || (tx_any && rm_mode != WCRC_RM_NONE)))
        begin
            primed <= 1'b1;
            cnt <= reload;
        end
        else if (timer_wake && rm_mode != WCRC_RM_NONE)
            cnt <= cnt_dec;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event outputs

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            always_on_supply_en <= 1'b0;
            watchdog_en <= 1'b0;
            wake_pin_en <= 1'b0;
            shutdown_start <= 1'b0;
            telegram_tx <= 1'b0;
            retx_tx <= 1'b0;
            teach_in_tx <= 1'b0;
            occupancy_tx <= 1'b0;
        end
        else
        begin
            always_on_supply_en <= (next_pwr == WCRC_PWR_ON);
            watchdog_en <= (next_pwr == WCRC_PWR_ON);
            wake_pin_en <= (next_pwr == WCRC_PWR_ON);
            shutdown_start <= shdn_ev;
            telegram_tx <= teach_wake || occ_send || retx_fire;
            retx_tx <= retx_fire;
            teach_in_tx <= teach_wake;
            occupancy_tx <= occ_send;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register port and interrupt

    logic [WCRC_EV_W-1:0] status;
    logic [WCRC_EV_W-1:0] mask;
    logic [WCRC_EV_W-1:0] ev;
    logic [WCRC_EV_W-1:0] next_status;
    logic [31:0] rd_mux;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign ev[WCRC_EV_TIMER] = timer_wake;
    assign ev[WCRC_EV_PIN] = pin_wake;
    assign ev[WCRC_EV_RETX] = retx_fire;
    assign ev[WCRC_EV_SHDN] = shdn_ev;
    assign wr_ctrl = wr_en && (addr == WCRC_REG_CTRL);
    assign wr_status = wr_en && (addr == WCRC_REG_STATUS);
    assign wr_mask = wr_en && (addr == WCRC_REG_MASK);
    // a new event beats a write-one-to-clear in the same cycle
    assign next_status = (status & ~(wr_status ? wr_data[WCRC_EV_W-1:0] : 4'h0)) | ev;
    assign rd_mux = (addr == WCRC_REG_CTRL) ? ctrl :
                    (addr == WCRC_REG_STATUS) ? {28'h000_0000, status} :
                    (addr == WCRC_REG_MASK) ? {28'h000_0000, mask} :
                    (addr == WCRC_REG_STATE) ? {19'h0_0000, powered, rm_mode, wp_mode, cnt} :
                    32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= WCRC_CTRL_RST;
            status <= WCRC_MASK_RST;
            mask <= WCRC_MASK_RST;
            rd_data <= 32'h0000_0000;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= {31'h0000_0000, wr_data[WCRC_CTRL_OCC_PROFILE]};
            if (wr_mask)
                mask <= wr_data[WCRC_EV_W-1:0];
            status <= next_status;
            rd_data <= rd_en ? rd_mux : 32'h0000_0000;
            irq <= |(next_status & (wr_mask ? wr_data[WCRC_EV_W-1:0] : mask));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_power_on;
        @(posedge ref_clk) disable iff (!rst_n)
        !powered && supply_above_on && !supply_at_or_below_off
        |=> always_on_supply_en && watchdog_en && wake_pin_en;
    endproperty
    a_power_on: assert property (p_power_on) else $error("enables missing after turn-on");

    property p_shutdown;
        @(posedge ref_clk) disable iff (!rst_n)
        powered && supply_at_or_below_off |=> shutdown_start && !always_on_supply_en;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown at turn-off");

    property p_resample;
        @(posedge ref_clk) disable iff (!rst_n)
        straps_ok && wake_any
        |=> wp_mode == $past({wake_period_sel1, wake_period_sel0})
            && rm_mode == $past({retx_rate_sel1, retx_rate_sel0});
    endproperty
    a_resample: assert property (p_resample) else $error("straps not resampled");

    property p_period;
        @(posedge ref_clk) disable iff (!rst_n)
        timer_wake |-> (wp_mode == WCRC_WP_1S && period == CYC_WAKE_A)
            || (wp_mode == WCRC_WP_10S && period == CYC_WAKE_B)
            || (wp_mode == WCRC_WP_100S && period == CYC_WAKE_C);
    endproperty
    a_period: assert property (p_period) else $error("wrong wake period");

    property p_no_cyclic;
        @(posedge ref_clk) disable iff (!rst_n)
        wp_mode == WCRC_WP_NONE |-> !timer_wake && tcnt == 32'h0000_0000;
    endproperty
    a_no_cyclic: assert property (p_no_cyclic) else $error("cyclic wake with none");

    property p_dec;
        @(posedge ref_clk) disable iff (!rst_n)
        primed && timer_wake && rm_mode != WCRC_RM_NONE && !tx_any && cnt > 8'd1
        |=> cnt == $past(cnt) - 8'd1;
    endproperty
    a_dec: assert property (p_dec) else $error("counter not decremented");

    property p_every;
        @(posedge ref_clk) disable iff (!rst_n)
        primed && timer_wake && rm_mode == WCRC_RM_EVERY |=> retx_tx && telegram_tx;
    endproperty
    a_every: assert property (p_every) else $error("missed per-wake retransmit");

    property p_never;
        @(posedge ref_clk) disable iff (!rst_n)
        rm_mode == WCRC_RM_NONE |=> !retx_tx;
    endproperty
    a_never: assert property (p_never) else $error("retransmit while disabled");

    property p_range;
        @(posedge ref_clk) disable iff (!rst_n)
        straps_ok && tx_any && rm_mode != WCRC_RM_NONE
        |=> cnt >= $past(rnd_lo) && cnt <= $past(rnd_hi);
    endproperty
    a_range: assert property (p_range) else $error("reload out of interval");

    property p_teach;
        @(posedge ref_clk) disable iff (!rst_n)
        powered && teach_q && !teach_in_wake_pin |=> teach_in_tx && telegram_tx;
    endproperty
    a_teach: assert property (p_teach) else $error("teach-in edge lost");

    property p_occ;
        @(posedge ref_clk) disable iff (!rst_n)
        powered && occ_q != occupancy_wake_pin && ctrl[WCRC_CTRL_OCC_PROFILE]
        |=> occupancy_tx && telegram_tx;
    endproperty
    a_occ: assert property (p_occ) else $error("occupancy change lost");

    c_retx_a: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rm_mode == WCRC_RM_RAND_A && retx_fire);
    c_teach: cover property (@(posedge ref_clk) disable iff (!rst_n) teach_in_tx);
    c_shdn: cover property (@(posedge ref_clk) disable iff (!rst_n) shutdown_start ##1 irq);

endmodule // wcrc_top

`default_nettype wire

// ### wcrc_straps.sv
`timescale 1ns/10ps
`default_nettype none

module wcrc_straps (
    input wire logic [1:0] wp_gnd,
    input wire logic [1:0] rm_gnd,
    input wire logic teach_press,
    input wire logic occ_low,
    output logic wake_period_sel0,
    output logic wake_period_sel1,
    output logic retx_rate_sel0,
    output logic retx_rate_sel1,
    output logic teach_in_wake_pin,
    output logic occupancy_wake_pin
);
    // an open strap floats high through its pull-up, a grounded one reads low
    assign wake_period_sel0 = !wp_gnd[0];
    assign wake_period_sel1 = !wp_gnd[1];
    assign retx_rate_sel0 = !rm_gnd[0];
    assign retx_rate_sel1 = !rm_gnd[1];
    // button pulls the pin to ground against its pull-up
    assign teach_in_wake_pin = !teach_press;
    // jumper holds the pin firmly on one rail, so it never floats
    assign occupancy_wake_pin = !occ_low;
endmodule // wcrc_straps

`default_nettype wire

// ### wcrc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none

module wcrc_top_bench
    import wcrc_pkg::*;
;
    localparam logic [31:0] PA = 32'h0000_0014;
    localparam logic [31:0] PB = 32'h0000_0032;
    localparam logic [31:0] PC = 32'h0000_0064;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sup_on = 1'b0;
    logic sup_off = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic teach_press = 1'b0;
    logic occ_low = 1'b0;
    logic [1:0] wp_gnd = 2'b11;
    logic [1:0] rm_gnd = 2'b11;
    logic [3:0] addr = 4'h0;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [31:0] rd_data;
    logic aon, wdg, wpe, shdn, tg, rtx, ttx, otx, irq;
    logic ws0, ws1, rs0, rs1, tpin, opin;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    wcrc_straps u_wcrc_straps (.wp_gnd(wp_gnd), .rm_gnd(rm_gnd), .teach_press(teach_press),
        .occ_low(occ_low), .wake_period_sel0(ws0), .wake_period_sel1(ws1),
        .retx_rate_sel0(rs0), .retx_rate_sel1(rs1), .teach_in_wake_pin(tpin),
        .occupancy_wake_pin(opin));

    // shortened wake periods keep the random retransmission runs affordable
    wcrc_top #(.CYC_WAKE_A(PA), .CYC_WAKE_B(PB), .CYC_WAKE_C(PC)) u_wcrc_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .supply_above_on(sup_on),
        .supply_at_or_below_off(sup_off), .wake_period_sel0(ws0), .wake_period_sel1(ws1),
        .retx_rate_sel0(rs0), .retx_rate_sel1(rs1), .teach_in_wake_pin(tpin),
        .occupancy_wake_pin(opin), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .always_on_supply_en(aon), .watchdog_en(wdg),
        .wake_pin_en(wpe), .shutdown_start(shdn), .telegram_tx(tg), .retx_tx(rtx),
        .teach_in_tx(ttx), .occupancy_tx(otx), .irq(irq));

    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_count++;
            end_of_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input bit ok, input string m);
        samples_checked++;
        if (!ok)
        begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
        d = rd_data;
    endtask

    function logic pick(input int s);
        case (s)
            0: return rtx;
            1: return irq;
            2: return ttx;
            3: return otx;
            default: return shdn;
        endcase
    endfunction

    task wait_for(input int s, input int lim, output int n);
        n = 0;
        while (n < lim && pick(s) !== 1'b1)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    // strap codes are {sel1, sel0}, a one meaning open
    task do_reset(input logic [1:0] wp, input logic [1:0] rm);
        rst_n <= 1'b0;
        sup_on <= 1'b0;
        sup_off <= 1'b0;
        wp_gnd <= ~wp;
        rm_gnd <= ~rm;
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        sup_on <= 1'b1;
        tick(1);
        chk(aon === 1'b0, "enabled early");
        tick(1);
        chk({aon, wdg, wpe} === 3'b111, "not powered");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_period;
        logic [31:0] per [4];
        int n;
        int t0;
        per = '{32'h0000_0000, PA, PB, PC};
        for (int i = 1; i < 4; i++)
        begin
            do_reset(i[1:0], 2'b00);
            wr(WCRC_REG_MASK, 32'h0000_0001);
            wait_for(1, 3 * PC, n);
            t0 = cyc;
            wr(WCRC_REG_STATUS, 32'h0000_0001);
            tick(2);
            wait_for(1, PC + 10, n);
            chk(cyc - t0 == per[i], "wake period");
        end
        $display("test period done");
    endtask

    task t_nowake;
        int n;
        do_reset(2'b00, 2'b00);
        wr(WCRC_REG_MASK, 32'h0000_0001);
        wait_for(1, 300, n);
        chk(n == 300, "cyclic wake with straps grounded");
        wp_gnd <= ~2'b01;
        teach_press <= 1'b1;
        tick(1);
        chk(ttx === 1'b0, "teach early");
        tick(1);
        chk({ttx, tg} === 2'b11, "teach telegram");
        tick(1);
        chk(ttx === 1'b0, "teach pulse long");
        wait_for(1, 3 * PA, n);
        chk(n < 3 * PA, "straps not resampled at pin wake");
        teach_press <= 1'b0;
        wait_for(2, 6, n);
        chk(n == 6, "teach on rising level");
        $display("test no-wake done");
    endtask

    task t_pins;
        logic [31:0] d;
        int n;
        do_reset(2'b00, 2'b01);
        rd(WCRC_REG_CTRL, d);
        chk(d === 32'h0000_0001, "ctrl reset");
        rd(WCRC_REG_MASK, d);
        chk(d === 32'h0000_0000, "mask reset");
        rd(4'hf, d);
        chk(d === 32'h0000_0000, "unmapped read");
        rd(WCRC_REG_STATE, d);
        chk((d & 32'h0000_1f00) === 32'h0000_1400, "strap readout");
        wr(WCRC_REG_MASK, 32'h0000_0002);
        occ_low <= 1'b1;
        tick(2);
        chk({otx, tg} === 2'b11, "occupancy telegram");
        wait_for(1, 4, n);
        chk(n < 4, "pin irq missing");
        wr(WCRC_REG_STATUS, 32'h0000_0002);
        tick(2);
        chk(irq === 1'b0, "irq not cleared");
        wr(WCRC_REG_MASK, 32'h0000_0000);
        occ_low <= 1'b0;
        tick(2);
        chk(otx === 1'b1, "occupancy rise");
        wait_for(1, 5, n);
        chk(n == 5, "masked irq");
        rd(WCRC_REG_STATUS, d);
        chk(d[WCRC_EV_PIN] === 1'b1, "sticky status");
        wr(WCRC_REG_CTRL, 32'h0000_0000);
        occ_low <= 1'b1;
        wait_for(3, 6, n);
        chk(n == 6, "occupancy sent without profile");
        $display("test pins done");
    endtask

    // ten-second wakes keep the every-wake mode inside the airtime budget
    task t_every;
        int n;
        do_reset(2'b10, 2'b10);
        wait_for(0, 2 * PB, n);
        for (int i = 0; i < 3; i++)
        begin
            tick(1);
            wait_for(0, PB + 5, n);
            chk(n + 1 == PB && tg === 1'b1, "retx every wake");
        end
        $display("test every done");
    endtask

    task t_rand(input logic [1:0] rm, input int lo, input int hi, input int p, input int k);
        int n;
        int g0;
        bit diff;
        diff = 1'b0;
        do_reset(p == PB ? 2'b10 : 2'b01, rm);
        wait_for(0, hi * p + p, n);
        for (int i = 0; i < k; i++)
        begin
            tick(1);
            wait_for(0, hi * p + p, n);
            n++;
            chk(n % p == 0 && n / p >= lo && n / p <= hi, "retx gap");
            if (i == 0)
                g0 = n;
            else if (n != g0)
                diff = 1'b1;
        end
        if (k > 4)
            chk(diff, "reload never varies");
        $display("test random done");
    endtask

    task t_never;
        int n;
        do_reset(2'b01, 2'b00);
        wait_for(0, 40 * PA, n);
        chk(n == 40 * PA, "retx in never mode");
        $display("test never done");
    endtask

    task t_off;
        int n;
        wr(WCRC_REG_MASK, 32'h0000_0008);
        sup_off <= 1'b1;
        tick(1);
        chk(shdn === 1'b0, "shutdown early");
        tick(1);
        chk({shdn, aon, wdg, wpe} === 4'b1000, "shutdown");
        tick(1);
        chk(shdn === 1'b0, "shutdown pulse long");
        wait_for(1, 3, n);
        chk(n < 3, "shutdown irq");
        teach_press <= 1'b1;
        wait_for(2, 6, n);
        chk(n == 6, "pin served while off");
        $display("test off done");
    endtask

    initial
    begin
        t_period;
        t_nowake;
        t_pins;
        t_every;
        t_rand(2'b11, 7, 14, PB, 8);
        t_rand(2'b01, 70, 140, PA, 3);
        t_never;
        t_off;
        end_of_test;
    end
endmodule // wcrc_top_bench

`default_nettype wire
